/* rtcfs_pkg.sv */
/*
  Shared constants, types and helpers for the counter flag/status register block.
  Assumes a 32-bit APB slave with one register per aligned word at four times the index.
*/
package rtcfs_pkg;
  localparam int RTCFS_DATA_W = 32;
  localparam int RTCFS_ADDR_W = 8;
  localparam int RTCFS_HALF_W = 16;
  localparam int RTCFS_REG_W = 8;
  // Register indices
  localparam logic [7:0] RTCFS_IDX_CTRL = 8'h00;
  localparam logic [7:0] RTCFS_IDX_ENSET = 8'h07;
  localparam logic [7:0] RTCFS_IDX_FLAGS = 8'h08;
  localparam logic [7:0] RTCFS_IDX_STATUS = 8'h0a;
  localparam logic [7:0] RTCFS_IDX_DBG = 8'h0b;
  localparam logic [7:0] RTCFS_IDX_TRIM = 8'h0c;
  localparam logic [7:0] RTCFS_IDX_COUNT = 8'h10;
  // Field positions
  localparam int RTCFS_BIT_OVF = 7;
  localparam int RTCFS_BIT_SYNC = 6;
  localparam int RTCFS_BIT_MATCH1 = 1;
  localparam int RTCFS_BIT_MATCH0 = 0;
  localparam int RTCFS_BIT_BUSY = 7;
  localparam int RTCFS_BIT_RUNDBG = 0;
  localparam int RTCFS_BIT_SIGN = 7;
  localparam int RTCFS_BIT_SWRST = 0;
  localparam int RTCFS_BIT_ENABLE = 1;
  localparam int RTCFS_MODE_LSB = 2;
  localparam int RTCFS_TRIM_MAG_W = 7;
  // Mode codes
  localparam logic [1:0] RTCFS_MODE_COUNT32 = 2'h0;
  localparam logic [1:0] RTCFS_MODE_COUNT16 = 2'h1;
  localparam logic [1:0] RTCFS_MODE_CALENDAR = 2'h2;
  // Flag and enable layouts per mode
  localparam logic [7:0] RTCFS_LAYOUT_ONE = 8'hc1;
  localparam logic [7:0] RTCFS_LAYOUT_TWO = 8'hc3;
  // Reset values
  localparam logic [7:0] RTCFS_REG_RESET = 8'h00;
  localparam logic [31:0] RTCFS_COUNT_RESET = 32'h0000_0000;
  // Timing defaults
  localparam int RTCFS_SYNC_CYCLES = 4;
  localparam int RTCFS_TRIM_ACC_W = 10;

  typedef enum {RTCFS_SYNC_IDLE, RTCFS_SYNC_RUN} rtcfs_sync_state_t;
  typedef enum {RTCFS_TGT_CTRL, RTCFS_TGT_TRIM, RTCFS_TGT_COUNT} rtcfs_target_t;

  function automatic logic rtcfs_hit(input logic [7:0] addr, input logic [7:0] idx);
    return addr == {idx[5:0], 2'b00};
  endfunction : rtcfs_hit

  function automatic logic [7:0] rtcfs_layout(input logic [1:0] mode);
    return (mode == RTCFS_MODE_COUNT16) ? RTCFS_LAYOUT_TWO : RTCFS_LAYOUT_ONE;
  endfunction : rtcfs_layout
endpackage : rtcfs_pkg

/* rtcfs_sync_tracker.sv */
/*
  Tracks one register synchronisation into the counter side and reports its end.
  Assumes start is a one-cycle pulse that only comes while busy is low.
*/
`timescale 1ns/1ps
module rtcfs_sync_tracker
  import rtcfs_pkg::*;
#(
  parameter int SYNC_CYCLES = RTCFS_SYNC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic quiet,
  output logic busy,
  output logic fin,
  output logic fin_loud
);
  localparam int CNT_W = $clog2(SYNC_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SYNC_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};

  rtcfs_sync_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic quiet_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RTCFS_SYNC_IDLE;
    end else begin
      case (state_r)
        RTCFS_SYNC_IDLE: begin
          if (start) begin
            state_r <= RTCFS_SYNC_RUN;
          end
        end
        RTCFS_SYNC_RUN: begin
          if (cnt_r == CNT_ZERO) begin
            state_r <= RTCFS_SYNC_IDLE;
          end
        end
        default: begin
          state_r <= RTCFS_SYNC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_ZERO;
    end else if (start) begin
      cnt_r <= CNT_LOAD;
    end else if (busy && cnt_r != CNT_ZERO) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // Enable and software reset end quietly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_r <= 1'b0;
    end else if (start) begin
      quiet_r <= quiet;
    end
  end

  assign busy = state_r == RTCFS_SYNC_RUN;
  assign fin = busy && cnt_r == CNT_ZERO;
  assign fin_loud = fin && !quiet_r;
endmodule : rtcfs_sync_tracker

/* rtcfs_regs.sv */
/*
  Flag, enable, status, debug, trim and counter registers of a real-time counter, APB slave.
  Assumes COUNTER_TICK is a one-cycle pulse per counter-clock cycle, synchronous to CLK_SYS.
*/
`timescale 1ns/1ps
// Overview of operation
// [RL1] Writing one sets enable bit, zero ignored
// [RL2] Overflow flag set on next counter tick
// [RL3] Interrupt when flag set and enabled
// [RL4] Writing one clears flag, zero ignored
// [RL5] Sync-done flag on busy fall, except enable/reset
// [RL6] Compare flags set one tick after match
// [RL7] Alarm flag set tick after calendar match
// [RL8] Busy high during domain synchronisation
// [RL9] Counter halts in debug unless run bit
// [RL10] Run-in-debug bit survives software reset
// [RL11] Trim sign: zero faster, one slower
// [RL12] Trim magnitude zero disables, else proportional
// [RL13] Trim writes protected and synchronised
// [RL14] 32-bit counter value, reset zero, read/write
// [RL15] 16-bit counter value in 16-bit mode
// [RL16] Counter accesses synchronised; software waits busy
// [RL17] Protected registers ignore writes while protected
// [RL18] Flag layout follows selected mode
module rtcfs_regs
  import rtcfs_pkg::*;
#(
  parameter int SYNC_CYCLES = RTCFS_SYNC_CYCLES,
  parameter int TRIM_ACC_W = RTCFS_TRIM_ACC_W
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [RTCFS_ADDR_W-1:0] PADDR,
  input wire logic [RTCFS_DATA_W-1:0] PWDATA,
  output logic [RTCFS_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic COUNTER_TICK,
  input wire logic DEBUG_HALT,
  input wire logic WRITE_PROTECT,
  input wire logic [RTCFS_DATA_W-1:0] MATCH_VALUE_0,
  input wire logic [RTCFS_HALF_W-1:0] MATCH_VALUE_1,
  output logic EVENT_OVERFLOW,
  output logic EVENT_MATCH,
  output logic IRQ
);
  logic [1:0] mode_r;
  logic enable_r;
  logic [RTCFS_REG_W-1:0] enset_r;
  logic [RTCFS_REG_W-1:0] flags_r;
  logic [RTCFS_REG_W-1:0] flags_nxt;
  logic run_dbg_r;
  logic [RTCFS_REG_W-1:0] trim_r;
  logic [RTCFS_DATA_W-1:0] count_r;
  logic [RTCFS_DATA_W-1:0] count_nxt;
  logic [TRIM_ACC_W-1:0] trim_acc_r;
  logic ovf_pend_r;
  logic [RTCFS_DATA_W-1:0] pend_data_r;
  rtcfs_target_t pend_sel_r;
  logic stall_r;
  logic [RTCFS_DATA_W-1:0] prdata_r;
  logic [RTCFS_DATA_W-1:0] rd_mux;
  logic ev_ovf_r;
  logic ev_match_r;

  logic access;
  logic done;
  logic wr_en;
  logic mapped;
  logic sync_reg;
  logic w_ctrl;
  logic w_enset;
  logic w_flags;
  logic w_dbg;
  logic w_trim;
  logic w_count;
  logic sync_start;
  logic sync_quiet;
  logic sync_busy;
  logic sync_fin;
  logic sync_fin_loud;
  logic apply;
  logic swrst_apply;
  logic run;
  logic tick_run;
  logic [TRIM_ACC_W:0] trim_sum;
  logic [1:0] step;
  logic [RTCFS_DATA_W:0] cnt_sum;
  logic wrap;
  logic mode16;
  logic match0;
  logic match1;
  logic [RTCFS_REG_W-1:0] set_bits;
  logic [RTCFS_REG_W-1:0] clr_bits;
  logic [RTCFS_REG_W-1:0] layout;

  assign layout = rtcfs_layout(mode_r);
  assign mode16 = mode_r == RTCFS_MODE_COUNT16;

  // Bus decode; counter accesses and control/trim writes stall while a sync is in flight
  assign access = PSEL && PENABLE;
  assign mapped = rtcfs_hit(PADDR, RTCFS_IDX_CTRL) || rtcfs_hit(PADDR, RTCFS_IDX_ENSET)
    || rtcfs_hit(PADDR, RTCFS_IDX_FLAGS) || rtcfs_hit(PADDR, RTCFS_IDX_STATUS)
    || rtcfs_hit(PADDR, RTCFS_IDX_DBG) || rtcfs_hit(PADDR, RTCFS_IDX_TRIM)
    || rtcfs_hit(PADDR, RTCFS_IDX_COUNT);
  // [RL16] Counter access synchronised
  assign sync_reg = rtcfs_hit(PADDR, RTCFS_IDX_COUNT)
    || (PWRITE && (rtcfs_hit(PADDR, RTCFS_IDX_TRIM) || rtcfs_hit(PADDR, RTCFS_IDX_CTRL)));
  assign done = access && !stall_r;
  assign wr_en = done && PWRITE;
  assign PREADY = done;
  assign PSLVERR = done && !mapped;
  assign PRDATA = prdata_r;

  // One extra cycle after busy falls lets read data pick up the applied value
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      stall_r <= 1'b0;
    end else begin
      stall_r <= PSEL && sync_reg && sync_busy;
    end
  end

  // [RL17] Protected writes dropped
  assign w_ctrl = wr_en && !WRITE_PROTECT && rtcfs_hit(PADDR, RTCFS_IDX_CTRL);
  assign w_enset = wr_en && !WRITE_PROTECT && rtcfs_hit(PADDR, RTCFS_IDX_ENSET);
  assign w_trim = wr_en && !WRITE_PROTECT && rtcfs_hit(PADDR, RTCFS_IDX_TRIM);
  assign w_count = wr_en && !WRITE_PROTECT && rtcfs_hit(PADDR, RTCFS_IDX_COUNT);
  assign w_flags = wr_en && rtcfs_hit(PADDR, RTCFS_IDX_FLAGS);
  assign w_dbg = wr_en && rtcfs_hit(PADDR, RTCFS_IDX_DBG);

  // [RL13] Trim goes through sync
  assign sync_start = w_ctrl || w_trim || w_count;
  assign sync_quiet = w_ctrl && (PWDATA[RTCFS_BIT_SWRST] || (PWDATA[RTCFS_BIT_ENABLE] && !enable_r));
  assign apply = sync_fin;
  assign swrst_apply = apply && pend_sel_r == RTCFS_TGT_CTRL && pend_data_r[RTCFS_BIT_SWRST];

  // [RL8] Busy tracking
  rtcfs_sync_tracker #(
    .SYNC_CYCLES(SYNC_CYCLES)
  ) u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .start(sync_start),
    .quiet(sync_quiet),
    .busy(sync_busy),
    .fin(sync_fin),
    .fin_loud(sync_fin_loud)
  );

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pend_data_r <= RTCFS_COUNT_RESET;
      pend_sel_r <= RTCFS_TGT_CTRL;
    end else if (sync_start) begin
      pend_data_r <= PWDATA;
      pend_sel_r <= w_trim ? RTCFS_TGT_TRIM : (w_count ? RTCFS_TGT_COUNT : RTCFS_TGT_CTRL);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      mode_r <= RTCFS_MODE_COUNT32;
      enable_r <= 1'b0;
    end else if (swrst_apply) begin
      mode_r <= RTCFS_MODE_COUNT32;
      enable_r <= 1'b0;
    end else if (apply && pend_sel_r == RTCFS_TGT_CTRL) begin
      mode_r <= pend_data_r[RTCFS_MODE_LSB +: 2];
      enable_r <= pend_data_r[RTCFS_BIT_ENABLE];
    end
  end

  // [RL1] Set-only enables
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      enset_r <= RTCFS_REG_RESET;
    end else if (swrst_apply) begin
      enset_r <= RTCFS_REG_RESET;
    end else if (w_enset) begin
      enset_r <= enset_r | (PWDATA[RTCFS_REG_W-1:0] & layout);
    end
  end

  // [RL10] Software reset leaves it; power-on reset or a zero write clears it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      run_dbg_r <= 1'b0;
    end else if (w_dbg) begin
      run_dbg_r <= PWDATA[RTCFS_BIT_RUNDBG];
    end
  end

  // [RL11] Sign and magnitude held after sync
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      trim_r <= RTCFS_REG_RESET;
    end else if (swrst_apply) begin
      trim_r <= RTCFS_REG_RESET;
    end else if (apply && pend_sel_r == RTCFS_TGT_TRIM) begin
      trim_r <= pend_data_r[RTCFS_REG_W-1:0];
    end
  end

  // [RL9] Debug halt gate
  assign run = enable_r && (!DEBUG_HALT || run_dbg_r);
  assign tick_run = COUNTER_TICK && run;

  // [RL12] Magnitude accumulates; carry adds or drops one count
  assign trim_sum = {1'b0, trim_acc_r}
    + {{(TRIM_ACC_W + 1 - RTCFS_TRIM_MAG_W){1'b0}}, trim_r[RTCFS_TRIM_MAG_W-1:0]};
  // [RL11] Sign picks extra or skipped count
  assign step = !trim_sum[TRIM_ACC_W] ? 2'h1 : (trim_r[RTCFS_BIT_SIGN] ? 2'h0 : 2'h2);
  assign cnt_sum = {1'b0, count_r} + {{(RTCFS_DATA_W - 1){1'b0}}, step};
  assign wrap = mode16 ? cnt_sum[RTCFS_HALF_W] : cnt_sum[RTCFS_DATA_W];
  // [RL15] Upper half held zero
  assign count_nxt = mode16 ? {{RTCFS_HALF_W{1'b0}}, cnt_sum[RTCFS_HALF_W-1:0]}
    : cnt_sum[RTCFS_DATA_W-1:0];

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      trim_acc_r <= {TRIM_ACC_W{1'b0}};
    end else if (swrst_apply) begin
      trim_acc_r <= {TRIM_ACC_W{1'b0}};
    end else if (tick_run) begin
      trim_acc_r <= trim_sum[TRIM_ACC_W-1:0];
    end
  end

  // [RL14] Counter value
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      count_r <= RTCFS_COUNT_RESET;
    end else if (swrst_apply) begin
      count_r <= RTCFS_COUNT_RESET;
    end else if (apply && pend_sel_r == RTCFS_TGT_COUNT) begin
      count_r <= mode16 ? {{RTCFS_HALF_W{1'b0}}, pend_data_r[RTCFS_HALF_W-1:0]} : pend_data_r;
    end else if (tick_run) begin
      count_r <= count_nxt;
    end
  end

  // [RL2] Wrap remembered until the next tick
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ovf_pend_r <= 1'b0;
    end else if (swrst_apply) begin
      ovf_pend_r <= 1'b0;
    end else if (tick_run) begin
      ovf_pend_r <= wrap;
    end
  end

  // [RL6] Compare and alarm match
  assign match0 = mode16 ? count_r[RTCFS_HALF_W-1:0] == MATCH_VALUE_0[RTCFS_HALF_W-1:0]
    : count_r == MATCH_VALUE_0;
  assign match1 = mode16 && count_r[RTCFS_HALF_W-1:0] == MATCH_VALUE_1;

  always_comb begin
    set_bits = RTCFS_REG_RESET;
    // [RL2] Overflow flag
    set_bits[RTCFS_BIT_OVF] = tick_run && ovf_pend_r;
    // [RL5] Sync done flag
    set_bits[RTCFS_BIT_SYNC] = sync_fin_loud;
    // [RL7] Alarm or compare zero
    set_bits[RTCFS_BIT_MATCH0] = tick_run && match0;
    set_bits[RTCFS_BIT_MATCH1] = tick_run && match1;
  end

  // [RL4] Write-one clear, set wins
  assign clr_bits = w_flags ? PWDATA[RTCFS_REG_W-1:0] : RTCFS_REG_RESET;
  assign flags_nxt = (flags_r & ~clr_bits) | (set_bits & layout);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flags_r <= RTCFS_REG_RESET;
    end else if (swrst_apply) begin
      flags_r <= RTCFS_REG_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ev_ovf_r <= 1'b0;
      ev_match_r <= 1'b0;
    end else begin
      ev_ovf_r <= set_bits[RTCFS_BIT_OVF];
      ev_match_r <= set_bits[RTCFS_BIT_MATCH0] || set_bits[RTCFS_BIT_MATCH1];
    end
  end
  assign EVENT_OVERFLOW = ev_ovf_r;
  assign EVENT_MATCH = ev_match_r;

  // [RL3] Enabled flags request interrupt
  assign IRQ = |(flags_r & enset_r & layout);

  // [RL18] Mode-dependent read layout
  always_comb begin
    rd_mux = {RTCFS_DATA_W{1'b0}};
    if (rtcfs_hit(PADDR, RTCFS_IDX_CTRL)) begin
      rd_mux[RTCFS_MODE_LSB +: 2] = mode_r;
      rd_mux[RTCFS_BIT_ENABLE] = enable_r;
    end else if (rtcfs_hit(PADDR, RTCFS_IDX_ENSET)) begin
      rd_mux[RTCFS_REG_W-1:0] = enset_r & layout;
    end else if (rtcfs_hit(PADDR, RTCFS_IDX_FLAGS)) begin
      rd_mux[RTCFS_REG_W-1:0] = flags_r & layout;
    end else if (rtcfs_hit(PADDR, RTCFS_IDX_STATUS)) begin
      rd_mux[RTCFS_BIT_BUSY] = sync_busy;
    end else if (rtcfs_hit(PADDR, RTCFS_IDX_DBG)) begin
      rd_mux[RTCFS_BIT_RUNDBG] = run_dbg_r;
    end else if (rtcfs_hit(PADDR, RTCFS_IDX_TRIM)) begin
      rd_mux[RTCFS_REG_W-1:0] = trim_r;
    end else if (rtcfs_hit(PADDR, RTCFS_IDX_COUNT)) begin
      rd_mux = count_r;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      prdata_r <= {RTCFS_DATA_W{1'b0}};
    end else if (PSEL) begin
      prdata_r <= rd_mux;
    end
  end

  default clocking dcb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  AST_ENABLE_STICKS: assert property ( // [RL1]
    !swrst_apply |=> (($past(enset_r) & ~enset_r) == RTCFS_REG_RESET))
    else $error("enable bit fell without reset");
  AST_OVF_NEXT_TICK: assert property ( // [RL2]
    tick_run && ovf_pend_r && !swrst_apply |=> flags_r[RTCFS_BIT_OVF])
    else $error("overflow flag not set on tick after wrap");
  AST_IRQ_FOLLOWS: assert property ( // [RL3]
    $rose(flags_r[RTCFS_BIT_OVF]) && enset_r[RTCFS_BIT_OVF] |-> IRQ)
    else $error("enabled flag gave no interrupt");
  AST_W1C_CLEARS: assert property ( // [RL4]
    w_flags && PWDATA[RTCFS_BIT_OVF] && !set_bits[RTCFS_BIT_OVF] |=> !flags_r[RTCFS_BIT_OVF])
    else $error("write one did not clear overflow flag");
  AST_SYNC_DONE: assert property ( // [RL5]
    sync_fin_loud && !swrst_apply |=> flags_r[RTCFS_BIT_SYNC] && !sync_busy)
    else $error("sync done flag missing at busy fall");
  AST_MATCH_ONE: assert property ( // [RL6]
    tick_run && match1 && !swrst_apply |=> flags_r[RTCFS_BIT_MATCH1])
    else $error("compare one flag not set");
  AST_ALARM: assert property ( // [RL7]
    tick_run && match0 && mode_r == RTCFS_MODE_CALENDAR && !swrst_apply |=> flags_r[RTCFS_BIT_MATCH0])
    else $error("alarm flag not set");
  AST_BUSY_SPAN: assert property ( // [RL8]
    sync_start |=> sync_busy ##[1:1000] !sync_busy)
    else $error("busy did not rise and fall around sync");
  AST_DEBUG_HALT: assert property ( // [RL9]
    DEBUG_HALT && !run_dbg_r && !apply |=> $stable(count_r))
    else $error("counter moved while halted in debug");
  AST_PROTECTED: assert property ( // [RL17]
    WRITE_PROTECT && wr_en && !sync_busy |=> !sync_busy && $stable(enset_r))
    else $error("protected write took effect");
  AST_LAYOUT: assert property ( // [RL18]
    !mode16 && rtcfs_hit(PADDR, RTCFS_IDX_FLAGS) |-> rd_mux[RTCFS_BIT_MATCH1] == 1'b0)
    else $error("compare one flag shown outside 16-bit mode");

  COV_IRQ: cover property ($rose(IRQ));
  COV_SYNC_DONE: cover property (sync_fin_loud);
  COV_OVERFLOW: cover property (set_bits[RTCFS_BIT_OVF]);
  COV_STALL: cover property (access && stall_r);
endmodule : rtcfs_regs

/* rtcfs_regs_test.sv */
/*
  Self-checking bench for the counter flag/status register block, driven over APB.
  Assumes the package constants, COUNTER_TICK as a one-cycle pulse, and a seven-bit trim accumulator.
*/
`timescale 1ns/1ps
module rtcfs_regs_test
  import rtcfs_pkg::*;
;
  localparam logic [7:0] A_CTL = RTCFS_IDX_CTRL << 2;
  localparam logic [7:0] A_ENS = RTCFS_IDX_ENSET << 2;
  localparam logic [7:0] A_FLG = RTCFS_IDX_FLAGS << 2;
  localparam logic [7:0] A_STA = RTCFS_IDX_STATUS << 2;
  localparam logic [7:0] A_DBG = RTCFS_IDX_DBG << 2;
  localparam logic [7:0] A_TRM = RTCFS_IDX_TRIM << 2;
  localparam logic [7:0] A_CNT = RTCFS_IDX_COUNT << 2;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, tick_in, dbg_halt, wprot, irq, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, match0, rdata_q, cnt_q;
  logic [15:0] match1;
  logic ev_ovf, ev_match;
  int n_ovf, n_match;
  int failures, total_checks;

  rtcfs_regs #(.TRIM_ACC_W(7)) u_rtcfs_regs (
    .CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .COUNTER_TICK(tick_in), .DEBUG_HALT(dbg_halt), .WRITE_PROTECT(wprot),
    .MATCH_VALUE_0(match0), .MATCH_VALUE_1(match1),
    .EVENT_OVERFLOW(ev_ovf), .EVENT_MATCH(ev_match), .IRQ(irq)
  );

  // Event pulses counted, so a pulse stuck high shows up as extra counts
  always @(posedge clk) begin
    if (!rst_n) begin
      n_ovf <= 0;
      n_match <= 0;
    end else begin
      if (ev_ovf === 1'b1) begin
        n_ovf <= n_ovf + 1;
      end
      if (ev_match === 1'b1) begin
        n_match <= n_match + 1;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Request held from setup until PREADY is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    #1;
    while (pready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      failures++;
      $display("[ERR] pready expected 1 seen %b", pready);
    end
    rdata_q = prdata;
    err_q = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rdata_q, e);
  endtask : rc

  // Comb IRQ is looked at once the edge's updates have landed
  task automatic ci(input logic e);
    #1;
    chk("irq", {31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask : ci

  // Bounded poll of the busy bit; software must not trust synced values before
  task automatic idle;
    int n;
    n = 0;
    apb(1'b0, A_STA, 32'h0000_0000);
    while (rdata_q[RTCFS_BIT_BUSY] !== 1'b0 && n < 20) begin
      apb(1'b0, A_STA, 32'h0000_0000);
      n++;
    end
    chk("busy end", rdata_q, 32'h0000_0000);
  endtask : idle

  task automatic tk(input int k);
    repeat (k) begin
      @(posedge clk);
      tick_in <= 1'b1;
      @(posedge clk);
      tick_in <= 1'b0;
    end
  endtask : tk

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tick_in = 1'b0;
    dbg_halt = 1'b0;
    wprot = 1'b0;
    match0 = 32'h00ff_0000;
    match1 = 16'h00ff;
    total_checks = 0;
    failures = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rc("flags rst", A_FLG, 32'h0000_0000);
    rc("status rst", A_STA, 32'h0000_0000);
    rc("dbg rst", A_DBG, 32'h0000_0000);
    rc("trim rst", A_TRM, 32'h0000_0000);
    rc("count rst", A_CNT, 32'h0000_0000);
    apb(1'b0, 8'hfc, 32'h0000_0000);
    chk("unmapped err", {31'h0000_0000, err_q}, 32'h0000_0001);
    chk("unmapped data", rdata_q, 32'h0000_0000);
    apb(1'b0, A_ENS, 32'h0000_0000);
    rc("enset zero", A_ENS, 32'h0000_0000);
    apb(1'b1, A_ENS, 32'h0000_00c1);
    rc("enset one", A_ENS, 32'h0000_00c1);
    apb(1'b1, A_ENS, 32'h0000_0000);
    rc("enset keep", A_ENS, 32'h0000_00c1);
    ci(1'b0);
    apb(1'b1, A_CNT, 32'h0000_0005);
    rc("busy set", A_STA, 32'h0000_0080);
    idle();
    rc("count wr", A_CNT, 32'h0000_0005);
    rc("sync done", A_FLG, 32'h0000_0040);
    ci(1'b1);
    apb(1'b1, A_FLG, 32'h0000_0000);
    rc("w0 flags", A_FLG, 32'h0000_0040);
    apb(1'b1, A_FLG, 32'h0000_0040);
    rc("w1c flags", A_FLG, 32'h0000_0000);
    ci(1'b0);
    @(posedge clk);
    wprot <= 1'b1;
    apb(1'b1, A_TRM, 32'h0000_0085);
    apb(1'b1, A_CNT, 32'h0000_0009);
    rc("wp busy", A_STA, 32'h0000_0000);
    rc("wp trim", A_TRM, 32'h0000_0000);
    rc("wp count", A_CNT, 32'h0000_0005);
    wprot <= 1'b0;
    apb(1'b1, A_CNT, 32'hffff_fffe);
    idle();
    apb(1'b1, A_FLG, 32'h0000_0040);
    match0 <= 32'hffff_ffff;
    apb(1'b1, A_CTL, 32'h0000_0002);
    idle();
    rc("quiet enable", A_FLG, 32'h0000_0000);
    tk(2);
    rc("match32", A_FLG, 32'h0000_0001);
    tk(1);
    rc("overflow32", A_FLG, 32'h0000_0081);
    ci(1'b1);
    chk("ovf event", n_ovf, 32'h0000_0001);
    chk("match event", n_match, 32'h0000_0001);
    apb(1'b1, A_FLG, 32'h0000_00ff);
    dbg_halt <= 1'b1;
    tk(3);
    rc("halted", A_CNT, 32'h0000_0001);
    apb(1'b1, A_DBG, 32'h0000_0001);
    rc("dbg bit", A_DBG, 32'h0000_0001);
    tk(2);
    rc("run dbg", A_CNT, 32'h0000_0003);
    apb(1'b1, A_TRM, 32'h0000_007f);
    idle();
    rc("trim up", A_TRM, 32'h0000_007f);
    tk(2);
    rc("faster", A_CNT, 32'h0000_0006);
    apb(1'b1, A_TRM, 32'h0000_00ff);
    idle();
    cnt_q = rdata_q;
    apb(1'b0, A_CNT, 32'h0000_0000);
    cnt_q = rdata_q;
    tk(2);
    apb(1'b0, A_CNT, 32'h0000_0000);
    chk("slower", {31'h0000_0000, (rdata_q - cnt_q) <= 32'h0000_0001}, 32'h0000_0001);
    apb(1'b1, A_TRM, 32'h0000_0000);
    idle();
    apb(1'b1, A_CTL, 32'h0000_0006);
    idle();
    apb(1'b1, A_ENS, 32'h0000_0002);
    rc("enset16", A_ENS, 32'h0000_00c3);
    apb(1'b1, A_CNT, 32'h0000_fffe);
    idle();
    match0 <= 32'h0000_1234;
    match1 <= 16'hffff;
    apb(1'b1, A_FLG, 32'h0000_00ff);
    rc("flags clr", A_FLG, 32'h0000_0000);
    tk(3);
    rc("wrap16", A_FLG, 32'h0000_0082);
    rc("count16", A_CNT, 32'h0000_0001);
    apb(1'b1, A_CTL, 32'h0000_000a);
    idle();
    apb(1'b1, A_CNT, 32'h0000_0010);
    idle();
    match0 <= 32'h0000_0011;
    apb(1'b1, A_FLG, 32'h0000_00ff);
    rc("enset cal", A_ENS, 32'h0000_00c1);
    tk(2);
    rc("alarm", A_FLG, 32'h0000_0001);
    ci(1'b1);
    apb(1'b1, A_FLG, 32'h0000_0001);
    ci(1'b0);
    apb(1'b1, A_CTL, 32'h0000_0001);
    idle();
    rc("dbg kept", A_DBG, 32'h0000_0001);
    rc("enset swr", A_ENS, 32'h0000_0000);
    rc("flags swr", A_FLG, 32'h0000_0000);
    rc("count swr", A_CNT, 32'h0000_0000);
    apb(1'b1, A_CNT, 32'h0000_0007);
    idle();
    rc("masked flag", A_FLG, 32'h0000_0040);
    ci(1'b0);
    @(posedge clk);
    wprot <= 1'b1;
    apb(1'b1, A_ENS, 32'h0000_00c1);
    wprot <= 1'b0;
    rc("wp enset", A_ENS, 32'h0000_0000);
    apb(1'b1, A_CNT, 32'h0000_0003);
    rc("stall read", A_CNT, 32'h0000_0003);
    chk("ovf events", n_ovf, 32'h0000_0002);
    chk("match events", n_match, 32'h0000_0003);
    test_done();
  end
endmodule : rtcfs_regs_test
